/* File: src/bit_control_literal_decoder.sv */
// Function
// - bit set, clear, toggle from top nibble
// - bit test skips; one cycle, else flush
// - conditional branches with eight condition codes
// - PC change costs a second no-op cycle
// - absolute jump and call are two words
// - lone 1111 word and zero word no-op
// - standby, watchdog clear, software reset words
// - push and pop return stack words
// - interrupt and subroutine return, fast bit
// - literal return loads working register
// - literal group opcode decode
// - literal flag update masks
// - bank literal load into low nibble
// - two-word twelve-bit pointer load
// - table read with four pointer modes
// - table write with four pointer modes
// - table write memory cycle runs until ended
// - port read-modify-write uses pin levels
// - timer-zero bit ops clear prescaler when it is assigned to the timer
// - bank-access bit selects access bank
// - twenty-bit absolute target assembly
`include "bcl_decode_cfg.svh"
`default_nettype none
module bit_control_literal_decoder
(
	input  wire logic                    clk_in,
	input  wire logic                    rstn_in,
	input  wire logic                    word_valid_in,
	input  wire logic [15:0]             word_in,
	input  wire logic                    zero_flag_in,
	input  wire logic                    carry_flag_in,
	input  wire logic                    overflow_flag_in,
	input  wire logic                    negative_flag_in,
	input  wire logic [7:0]              operand_in,
	input  wire logic                    target_is_port_in,
	input  wire logic                    target_is_timer_zero_in,
	input  wire logic                    prescaler_on_timer_in,
	input  wire logic                    table_write_done_in,
	output logic                         bit_op_out,
	output logic [7:0]                   bit_result_out,
	output logic                         read_pins_out,
	output logic                         prescaler_clear_out,
	output logic [2:0]                   bit_pos_out,
	output logic [7:0]                   reg_addr_out,
	output logic                         use_access_bank_out,
	output logic                         pc_load_out,
	output logic                         pc_relative_out,
	output logic [19:0]                  pc_target_out,
	output logic                         call_out,
	output logic                         fast_out,
	output logic                         return_out,
	output logic                         irq_return_out,
	output logic                         push_out,
	output logic                         pop_out,
	output logic                         standby_out,
	output logic                         watchdog_clear_out,
	output logic                         sw_reset_out,
	output bcl_decode_pkg::alu_op_t      alu_op_out,
	output logic [7:0]                   literal_out,
	output logic [4:0]                   flag_update_out,
	output logic                         working_register_load_out,
	output logic                         bank_select_load_out,
	output logic [3:0]                   bank_select_register_out,
	output logic                         pointer_load_out,
	output logic [1:0]                   indirect_pointer_sel_out,
	output logic [11:0]                  pointer_literal_out,
	output logic                         table_read_out,
	output logic                         table_write_out,
	output bcl_decode_pkg::ptr_mode_t    table_ptr_mode_out,
	output logic                         table_write_busy_out,
	output logic                         stall_out
);
	import bcl_decode_pkg::*;

	////////////////////////////////////////////////////////////////
	dec_state_t  state;
	dec_state_t  next_state;
	logic [1:0]  flush_left;
	logic [1:0]  next_flush_left;
	logic [7:0]  first_low;
	logic [7:0]  next_first_low;
	logic [7:0]  first_high;
	logic [7:0]  next_first_high;
	logic [3:0]  bank;
	logic [3:0]  next_bank;
	logic        w_bit_op;
	logic [7:0]  w_bit_result;
	logic        w_pins;
	logic        w_presc;
	logic [2:0]  w_bit_pos;
	logic [7:0]  w_addr;
	logic        w_access;
	logic        w_pc_load;
	logic        w_pc_rel;
	logic [19:0] w_target;
	logic        w_call;
	logic        w_fast;
	logic        w_ret;
	logic        w_iret;
	logic        w_push;
	logic        w_pop;
	logic        w_standby;
	logic        w_wdt;
	logic        w_reset;
	alu_op_t     w_alu;
	logic [7:0]  w_lit;
	logic [4:0]  w_flags;
	logic        w_wload;
	logic        w_bload;
	logic        w_pload;
	logic [1:0]  w_psel;
	logic [11:0] w_plit;
	logic        w_trd;
	logic        w_twr;
	ptr_mode_t   w_pmode;
	logic        cond_true;
	logic        bit_val;

	// Flags order: carry, digit carry, zero, overflow, negative
	localparam logic [4:0] FLAGS_ARITH = 5'h1f;
	localparam logic [4:0] FLAGS_LOGIC = 5'h05;

	always_comb
	begin
		unique case (word_in[10:8])
			3'h0: cond_true = zero_flag_in;
			3'h1: cond_true = !zero_flag_in;
			3'h2: cond_true = carry_flag_in;
			3'h3: cond_true = !carry_flag_in;
			3'h4: cond_true = overflow_flag_in;
			3'h5: cond_true = !overflow_flag_in;
			3'h6: cond_true = negative_flag_in;
			default: cond_true = !negative_flag_in;
		endcase
	end
	assign bit_val = operand_in[word_in[11:9]];

	////////////////////////////////////////////////////////////////
	always_comb
	begin
		next_state = state;
		next_flush_left = flush_left;
		next_first_low = first_low;
		next_first_high = first_high;
		next_bank = bank;
		{w_bit_op, w_pins, w_presc, w_pc_load, w_pc_rel, w_call, w_fast} = 7'h00;
		{w_ret, w_iret, w_push, w_pop, w_standby, w_wdt, w_reset} = 7'h00;
		{w_wload, w_bload, w_pload, w_trd, w_twr} = 5'h00;
		w_bit_result = operand_in;
		w_bit_pos = word_in[11:9];
		w_addr = word_in[7:0];
		w_access = !word_in[8];
		w_target = 20'h00000;
		w_alu = ALU_NONE;
		w_lit = word_in[7:0];
		w_flags = 5'h00;
		w_psel = first_low[5:4];
		w_plit = {first_low[3:0], word_in[7:0]};
		w_pmode = ptr_mode_t'({2'h0, word_in[1:0]});
		unique case (state)
			ST_FETCH:
			begin
				if (word_valid_in)
				begin
					next_first_low = word_in[7:0];
					next_first_high = word_in[15:8];
					unique case (word_in[15:12])
						`NIB_BIT_SET, `NIB_BIT_CLEAR, `NIB_BIT_TOGGLE:
						begin
							w_bit_op = 1'b1;
							if (word_in[15:12] == `NIB_BIT_SET)
								w_bit_result[word_in[11:9]] = 1'b1;
							else if (word_in[15:12] == `NIB_BIT_CLEAR)
								w_bit_result[word_in[11:9]] = 1'b0;
							else
								w_bit_result[word_in[11:9]] = !bit_val;
							w_pins = target_is_port_in;
							w_presc = target_is_timer_zero_in && prescaler_on_timer_in;
						end
						`NIB_SKIP_ZERO, `NIB_SKIP_ONE:
						begin
							// Skip flushes the next word; a two-word one needs a second flush
							if (bit_val == (word_in[15:12] == `NIB_SKIP_ONE))
							begin
								next_state = ST_FLUSH;
								next_flush_left = 2'h1;
							end
						end
						`NIB_REL:
						begin
							w_pc_load = 1'b1;
							w_pc_rel = 1'b1;
							w_call = word_in[11];
							w_target = {{9{word_in[10]}}, word_in[10:0]};
							next_state = ST_FLUSH;
							next_flush_left = 2'h1;
						end
						`NIB_BRANCH:
						begin
							if (!word_in[11])
							begin
								if (cond_true)
								begin
									w_pc_load = 1'b1;
									w_pc_rel = 1'b1;
									w_target = {{12{word_in[7]}}, word_in[7:0]};
									next_state = ST_FLUSH;
									next_flush_left = 2'h1;
								end
							end
							else if (word_in[15:8] == `HI_ABS_JUMP || word_in[15:9] == `HI_CALL_MSB7
								|| word_in[15:8] == `HI_PTR_LOAD)
								next_state = ST_EXT;
						end
						`NIB_EXT:
						begin
						end
						default:
						begin
							if (word_in == `W_STANDBY)
								w_standby = 1'b1;
							if (word_in == `W_WDT_CLEAR)
								w_wdt = 1'b1;
							if (word_in == `W_SW_RESET)
								w_reset = 1'b1;
							if (word_in == `W_PUSH)
								w_push = 1'b1;
							if (word_in == `W_POP)
								w_pop = 1'b1;
							if (word_in[15:1] == `W_IRQ_RET_MSB15 || word_in[15:1] == `W_SUB_RET_MSB15)
							begin
								w_ret = 1'b1;
								w_iret = !word_in[1];
								w_fast = word_in[0];
								next_state = ST_FLUSH;
								next_flush_left = 2'h1;
							end
							if (word_in[15:8] == `HI_LIT_RETURN)
							begin
								w_ret = 1'b1;
								w_wload = 1'b1;
								w_alu = ALU_MOVE;
								next_state = ST_FLUSH;
								next_flush_left = 2'h1;
							end
							unique case (word_in[15:8])
								`HI_LIT_ADD: w_alu = ALU_ADD;
								`HI_LIT_SUB: w_alu = ALU_SUB;
								`HI_LIT_AND: w_alu = ALU_AND;
								`HI_LIT_OR: w_alu = ALU_OR;
								`HI_LIT_XOR: w_alu = ALU_XOR;
								`HI_LIT_MOVE: w_alu = ALU_MOVE;
								`HI_LIT_MUL: w_alu = ALU_MUL;
								default: ;
							endcase
							if (w_alu == ALU_ADD || w_alu == ALU_SUB)
								w_flags = FLAGS_ARITH;
							else if (w_alu == ALU_AND || w_alu == ALU_OR || w_alu == ALU_XOR)
								w_flags = FLAGS_LOGIC;
							if (w_alu != ALU_NONE && w_alu != ALU_MUL)
								w_wload = 1'b1;
							if (word_in[15:4] == `W_BANK_MSB12)
							begin
								w_bload = 1'b1;
								next_bank = word_in[3:0];
							end
							if (word_in[15:2] == `W_TBL_RD_MSB14 || word_in[15:2] == `W_TBL_WR_MSB14)
							begin
								w_trd = !word_in[2];
								w_twr = word_in[2];
								next_state = ST_FLUSH;
								next_flush_left = 2'h1;
							end
						end
					endcase
				end
			end
			ST_EXT:
			begin
				if (word_valid_in)
				begin
					next_state = ST_FETCH;
					if (first_high == `HI_PTR_LOAD)
					begin
						w_pload = 1'b1;
					end
					else
					begin
						w_pc_load = 1'b1;
						w_call = (first_high != `HI_ABS_JUMP);
						// Only a call, not an absolute jump, carries the fast-save request bit
						w_fast = (first_high != `HI_ABS_JUMP) && first_high[0];
						w_target = {word_in[11:0], first_low};
					end
				end
			end
			ST_FLUSH:
			begin
				if (word_valid_in)
				begin
					// Skipped word is a first word: its extension is flushed too
					if (flush_left == 2'h1 && (word_in[15:8] == `HI_ABS_JUMP || word_in[15:9] == `HI_CALL_MSB7
						|| word_in[15:8] == `HI_PTR_LOAD))
						next_flush_left = 2'h2;
					else
						next_state = ST_FETCH;
					if (flush_left == 2'h2)
						next_state = ST_FETCH;
				end
			end
			default: next_state = ST_FETCH;
		endcase
	end

	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			state <= ST_FETCH;
			flush_left <= 2'h0;
			first_low <= 8'h00;
			first_high <= 8'h00;
			bank <= 4'h0;
		end
		else
		begin
			state <= next_state;
			flush_left <= next_flush_left;
			first_low <= next_first_low;
			first_high <= next_first_high;
			bank <= next_bank;
		end
	end

	////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			{bit_op_out, read_pins_out, prescaler_clear_out, pc_load_out, pc_relative_out} <= 5'h00;
			{call_out, fast_out, return_out, irq_return_out, push_out, pop_out} <= 6'h00;
			{standby_out, watchdog_clear_out, sw_reset_out, working_register_load_out} <= 4'h0;
			{bank_select_load_out, pointer_load_out, table_read_out, table_write_out} <= 4'h0;
			bit_result_out <= 8'h00;
			bit_pos_out <= 3'h0;
			reg_addr_out <= 8'h00;
			use_access_bank_out <= 1'b0;
			pc_target_out <= 20'h00000;
			alu_op_out <= ALU_NONE;
			literal_out <= 8'h00;
			flag_update_out <= 5'h00;
			indirect_pointer_sel_out <= 2'h0;
			pointer_literal_out <= 12'h000;
			table_ptr_mode_out <= PTR_NONE;
		end
		else
		begin
			{bit_op_out, read_pins_out, prescaler_clear_out, pc_load_out, pc_relative_out} <=
				{w_bit_op, w_pins, w_presc, w_pc_load, w_pc_rel};
			{call_out, fast_out, return_out, irq_return_out, push_out, pop_out} <=
				{w_call, w_fast, w_ret, w_iret, w_push, w_pop};
			{standby_out, watchdog_clear_out, sw_reset_out, working_register_load_out} <=
				{w_standby, w_wdt, w_reset, w_wload};
			{bank_select_load_out, pointer_load_out, table_read_out, table_write_out} <=
				{w_bload, w_pload, w_trd, w_twr};
			bit_result_out <= w_bit_result;
			bit_pos_out <= w_bit_pos;
			reg_addr_out <= w_addr;
			use_access_bank_out <= w_access;
			pc_target_out <= w_target;
			alu_op_out <= w_alu;
			literal_out <= w_lit;
			flag_update_out <= w_flags;
			indirect_pointer_sel_out <= w_psel;
			pointer_literal_out <= w_plit;
			table_ptr_mode_out <= w_pmode;
		end
	end
	assign bank_select_register_out = bank;
	assign stall_out = (state == ST_FLUSH);

	table_write_timer u_twt
	(
		.clk_in   (clk_in),
		.rstn_in  (rstn_in),
		.start_in (table_write_out),
		.done_in  (table_write_done_in),
		.busy_out (table_write_busy_out)
	);

	////////////////////////////////////////////////////////////////
	AST_SKIP_FLUSH: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(state == ST_FETCH && word_valid_in && word_in[15:12] == `NIB_SKIP_ZERO && !bit_val)
		|=> state == ST_FLUSH) else $error("skip not taken");
	AST_BRANCH_NOT_TAKEN: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(state == ST_FETCH && word_valid_in && word_in[15:11] == 5'h1c && !cond_true)
		|=> state == ST_FETCH && !pc_load_out) else $error("untaken branch stalled");
	AST_REL_TWO_CYCLE: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(state == ST_FETCH && word_valid_in && word_in[15:12] == `NIB_REL)
		|=> pc_load_out && pc_relative_out && stall_out) else $error("relative jump timing");
	AST_ABS_TARGET: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(state == ST_EXT && word_valid_in && first_high != `HI_PTR_LOAD)
		|=> pc_load_out && pc_target_out == {$past(word_in[11:0]), $past(first_low)})
		else $error("absolute target wrong");
	AST_LONE_EXT_NOP: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(state == ST_FETCH && word_valid_in && word_in[15:12] == `NIB_EXT)
		|=> !pc_load_out && !working_register_load_out && state == ST_FETCH) else $error("lone word acted");
	AST_LIT_FLAGS: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(alu_op_out == ALU_AND) |-> flag_update_out == FLAGS_LOGIC) else $error("logic flags wrong");
	AST_BANK_LOAD: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(state == ST_FETCH && word_valid_in && word_in[15:4] == `W_BANK_MSB12)
		|=> bank_select_register_out == $past(word_in[3:0])) else $error("bank load wrong");
	AST_PRESCALER: assert property (@(posedge clk_in) disable iff (!rstn_in)
		prescaler_clear_out |-> bit_op_out) else $error("prescaler cleared without bit op");
	AST_TABLE_BUSY: assert property (@(posedge clk_in) disable iff (!rstn_in)
		table_write_out ##1 !table_write_done_in |-> table_write_busy_out) else $error("write not held");
endmodule
`default_nettype wire

/* File: src/bcl_decode_cfg.svh */
`ifndef BCL_DECODE_CFG_SVH
`define BCL_DECODE_CFG_SVH
`define NIB_BIT_SET       4'h8
`define NIB_BIT_CLEAR     4'h9
`define NIB_BIT_TOGGLE    4'h7
`define NIB_SKIP_ZERO     4'hb
`define NIB_SKIP_ONE      4'ha
`define NIB_REL           4'hd
`define NIB_BRANCH        4'he
`define NIB_EXT           4'hf
`define HI_ABS_JUMP       8'hef
`define HI_PTR_LOAD       8'hee
`define HI_CALL_MSB7      7'h76
`define HI_LIT_RETURN     8'h0c
`define HI_LIT_ADD        8'h0f
`define HI_LIT_SUB        8'h08
`define HI_LIT_AND        8'h0b
`define HI_LIT_OR         8'h09
`define HI_LIT_XOR        8'h0a
`define HI_LIT_MOVE       8'h0e
`define HI_LIT_MUL        8'h0d
`define W_NOP             16'h0000
`define W_STANDBY         16'h0003
`define W_WDT_CLEAR       16'h0004
`define W_PUSH            16'h0005
`define W_POP             16'h0006
`define W_DEC_ADJ         16'h0007
`define W_SW_RESET        16'h00ff
`define W_IRQ_RET_MSB15   15'h0008
`define W_SUB_RET_MSB15   15'h0009
`define W_TBL_RD_MSB14    14'h0002
`define W_TBL_WR_MSB14    14'h0003
`define W_BANK_MSB12      12'h010
`define PTR_SEL_TOP2      2'h0
`define EXT2_PTR_TOP4     4'h0
`define TABLE_WR_CYCLES   8'h10
`endif

/* File: src/bcl_decode_pkg.sv */
`default_nettype none
package bcl_decode_pkg;
	typedef enum logic [3:0]
	{
		PTR_NONE = 4'h0,
		PTR_POST_INC = 4'h1,
		PTR_POST_DEC = 4'h2,
		PTR_PRE_INC = 4'h3
	} ptr_mode_t;
	typedef enum logic [3:0]
	{
		ALU_NONE = 4'h0,
		ALU_ADD = 4'h1,
		ALU_SUB = 4'h2,
		ALU_AND = 4'h3,
		ALU_OR = 4'h4,
		ALU_XOR = 4'h5,
		ALU_MOVE = 4'h6,
		ALU_MUL = 4'h7
	} alu_op_t;
	typedef enum logic [2:0]
	{
		ST_FETCH = 3'b001,
		ST_EXT = 3'b010,
		ST_FLUSH = 3'b100
	} dec_state_t;
endpackage
`default_nettype wire

/* File: src/table_write_timer.sv */
`include "bcl_decode_cfg.svh"
`default_nettype none
module table_write_timer
(
	input  wire logic clk_in,
	input  wire logic rstn_in,
	input  wire logic start_in,
	input  wire logic done_in,
	output logic      busy_out
);
	logic [7:0] count;
	logic [7:0] next_count;
	always_comb
	begin
		next_count = count;
		if (start_in && count == 8'h00)
			next_count = `TABLE_WR_CYCLES;
		else if (done_in)
			next_count = 8'h00;
		else if (count > 8'h01)
			next_count = count - 8'h01;
	end
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			count <= 8'h00;
		else
			count <= next_count;
	end
	// Held until the memory side ends it, not the instruction
	assign busy_out = (count != 8'h00);
endmodule
`default_nettype wire

/* File: test/prog_mem.sv */
`default_nettype none
module prog_mem
(
	input  wire logic        clk_in,
	input  wire logic        we_in,
	input  wire logic [7:0]  waddr_in,
	input  wire logic [15:0] wdata_in,
	input  wire logic        en_in,
	input  wire logic [7:0]  addr_in,
	output logic      [15:0] word_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] rom [256];
	logic [15:0] last;
	initial last = 16'h0000;
	always @(posedge clk_in)
	begin
		if (we_in)
			rom[waddr_in] <= wdata_in;
		if (en_in)
			last <= rom[addr_in];
	end
	// Idle bus shows the inverse of the last word, so stale data cannot pass as a fetch
	assign word_out = en_in ? rom[addr_in] : ~last;
endmodule
`default_nettype wire

/* File: test/testbench.sv */
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import bcl_decode_pkg::*;
	typedef struct packed {logic [26:0] c; logic [26:0] x; logic [2:0] s; logic [19:0] d;} note_t;
	typedef struct packed {logic [15:0] w; logic [7:0] op; logic [3:0] fl; logic [2:0] q; note_t n;} entry_t;
	localparam logic [26:0] PCL = 27'h4000000, CALL = 27'h2000000, RET = 27'h1000000, IRQ = 27'h800000;
	localparam logic [26:0] FAST = 27'h400000, PUSH = 27'h200000, POP = 27'h100000, STBY = 27'h80000;
	localparam logic [26:0] WDT = 27'h40000, SWR = 27'h20000, WRL = 27'h10000, BSL = 27'h8000, PTR = 27'h4000;
	localparam logic [26:0] TRD = 27'h2000, TWR = 27'h1000, BIT = 27'h800, PINS = 27'h400, PRE = 27'h200;
	localparam logic [26:0] ALLX = 27'h7ffffff, ALUM = 27'h1e0;
	logic clk_in = 1'b0, rstn_in = 1'b0, word_valid_in = 1'b0, we = 1'b0, took = 1'b0, done_in = 1'b0;
	logic [7:0] waddr = 8'h00, raddr = 8'h00, operand_in = 8'h00, k, op, res;
	logic [15:0] wdata = 16'h0000, word;
	logic [3:0] fl = 4'h0, flags_in = 4'h0;
	logic [2:0] q = 3'h0, qual_in = 3'h0, b;
	logic a;
	logic [11:0] h;
	logic [10:0] n11;
	logic [26:0] got;
	logic [19:0] gd;
	note_t n;
	entry_t prog[$];
	note_t exp_q[$];
	int seed, cyc = 0, miscompares = 0, total_checks = 0, tno = 0;
	logic bit_op, rd_pins, pre_clr, pc_load, pc_rel, call_o, fast_o, ret_o, irq_o, push_o, pop_o, stby_o;
	logic wdt_o, swr_o, wrl_o, bsl_o, ptr_o, trd_o, twr_o, busy, stall;
	logic [7:0] bit_res, reg_addr, lit;
	logic [2:0] bit_pos;
	logic acc;
	logic [19:0] target;
	alu_op_t alu;
	ptr_mode_t tmode;
	logic [4:0] fupd;
	logic [3:0] bank;
	logic [1:0] psel;
	logic [11:0] plit;
	always #5 clk_in = ~clk_in;
	prog_mem mem (.clk_in(clk_in), .we_in(we), .waddr_in(waddr), .wdata_in(wdata), .en_in(word_valid_in),
		.addr_in(raddr), .word_out(word));
	bit_control_literal_decoder dut (.clk_in(clk_in), .rstn_in(rstn_in), .word_valid_in(word_valid_in),
		.word_in(word), .zero_flag_in(flags_in[3]), .carry_flag_in(flags_in[2]), .overflow_flag_in(flags_in[1]),
		.negative_flag_in(flags_in[0]), .operand_in(operand_in), .target_is_port_in(qual_in[2]),
		.target_is_timer_zero_in(qual_in[1]), .prescaler_on_timer_in(qual_in[0]), .table_write_done_in(done_in),
		.bit_op_out(bit_op), .bit_result_out(bit_res), .read_pins_out(rd_pins), .prescaler_clear_out(pre_clr),
		.bit_pos_out(bit_pos), .reg_addr_out(reg_addr), .use_access_bank_out(acc), .pc_load_out(pc_load),
		.pc_relative_out(pc_rel), .pc_target_out(target), .call_out(call_o), .fast_out(fast_o),
		.return_out(ret_o), .irq_return_out(irq_o), .push_out(push_o), .pop_out(pop_o), .standby_out(stby_o),
		.watchdog_clear_out(wdt_o), .sw_reset_out(swr_o), .alu_op_out(alu), .literal_out(lit),
		.flag_update_out(fupd), .working_register_load_out(wrl_o), .bank_select_load_out(bsl_o),
		.bank_select_register_out(bank), .pointer_load_out(ptr_o), .indirect_pointer_sel_out(psel),
		.pointer_literal_out(plit), .table_read_out(trd_o), .table_write_out(twr_o),
		.table_ptr_mode_out(tmode), .table_write_busy_out(busy), .stall_out(stall));
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [46:0] g, input logic [46:0] e);
		total_checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task results;
		$display("checks %0d miscompares %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	always @(posedge clk_in)
	begin
		took <= word_valid_in;
		cyc++;
		if (cyc == 20000)
		begin
			miscompares++;
			results();
		end
	end
	// Every taken word owes one note, flushed words included
	always @(negedge clk_in)
	begin
		if (rstn_in && took)
		begin
			n = (exp_q.size() > 0) ? exp_q.pop_front() : note_t'{ALLX, 27'h0, 3'h0, 20'hfffff};
			got = {pc_load, call_o, ret_o, irq_o, fast_o, push_o, pop_o, stby_o, wdt_o, swr_o, wrl_o, bsl_o, ptr_o,
				trd_o, twr_o, bit_op, rd_pins, pre_clr, alu, fupd};
			case (n.s)
				3'h1, 3'h7: gd = target;
				3'h2: gd = {12'h000, lit};
				3'h3: gd = {bit_pos, acc, reg_addr, bit_res};
				3'h4: gd = {6'h00, psel, plit};
				3'h5: gd = {16'h0000, tmode};
				3'h6: gd = {16'h0000, bank};
				default: gd = n.d;
			endcase
			chk({got & ~n.x, gd}, {n.c & ~n.x, n.d});
			// Relative targets flush the next word; absolute ones already spent their second cycle
			if (n.s == 3'h1 || n.s == 3'h7)
				chk({45'h0, pc_rel, stall}, {45'h0, {2{n.s == 3'h1}}});
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic add(input logic [15:0] w, input logic [26:0] c, x, input logic [2:0] s, input logic [19:0] d);
		prog.push_back('{w, op, fl, q, '{c, x, s, d}});
	endtask
	task follow(input logic flushed);
		k = 8'($random(seed));
		add({8'h0e, k}, flushed ? 27'h0 : 27'h0c0, WRL, flushed ? 3'h0 : 3'h2, flushed ? 20'h0 : {12'h0, k});
	endtask
	task dc;
		add(16'h0000, 27'h0, ALLX, 3'h0, 20'h0);
	endtask
	task go;
		foreach (prog[i])
		begin
			@(negedge clk_in);
			we = 1'b1;
			waddr = 8'(i);
			wdata = prog[i].w;
		end
		@(negedge clk_in);
		we = 1'b0;
		foreach (prog[i])
		begin
			@(negedge clk_in);
			word_valid_in = 1'b1;
			raddr = 8'(i);
			operand_in = prog[i].op;
			flags_in = prog[i].fl;
			qual_in = prog[i].q;
			exp_q.push_back(prog[i].n);
		end
		@(negedge clk_in);
		word_valid_in = 1'b0;
		repeat (2) @(negedge clk_in);
		prog.delete();
		$display("test %0d done", tno++);
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		seed = 26561;
		repeat (16) @(negedge clk_in);
		rstn_in = 1'b1;
		for (int i = 0; i < 9; i++)
		begin
			{op, b, a, k, q} = 23'($random(seed));
			res = (i % 3 == 0) ? (op & ~(8'h01 << b)) : (i % 3 == 1) ? (op | (8'h01 << b)) : (op ^ (8'h01 << b));
			add({(i % 3 == 0) ? 4'h9 : (i % 3 == 1) ? 4'h8 : 4'h7, b, a, k},
				BIT | (q[2] ? PINS : 27'h0) | (q[1] & q[0] ? PRE : 27'h0), 27'h0, 3'h3, {b, ~a, k, res});
		end
		go();
		for (int i = 0; i < 4; i++)
		begin
			{op, b, a, k} = 20'($random(seed));
			op[b] = i[1];
			add({i[0] ? 4'ha : 4'hb, b, a, k}, 27'h0, BIT | PINS | PRE, 3'h0, 20'h0);
			if (i == 3)
			begin
				add({8'hef, k}, 27'h0, 27'h0, 3'h0, 20'h0);
				add({4'hf, 12'(op)}, 27'h0, 27'h0, 3'h0, 20'h0);
			end
			follow(i[0] == i[1] && i != 3);
		end
		go();
		for (int i = 0; i < 8; i++)
		begin
			{fl, k} = 12'($random(seed));
			a = fl[3 - i[2:1]] ^ i[0];
			add({5'h1c, 3'(i), k}, a ? PCL : 27'h0, 27'h0, a ? 3'h1 : 3'h0, a ? {{12{k[7]}}, k} : 20'h0);
			follow(a);
		end
		for (int i = 0; i < 2; i++)
		begin
			n11 = 11'($random(seed));
			add({4'hd, i[0], n11}, PCL | (i[0] ? CALL : 27'h0), 27'h0, 3'h1, {{9{n11[10]}}, n11});
			follow(1'b1);
		end
		go();
		for (int i = 0; i < 3; i++)
		begin
			{h, k} = 20'($random(seed));
			add({(i == 0) ? 8'hef : {7'h76, i[1]}, k}, 27'h0, 27'h0, 3'h0, 20'h0);
			add({4'hf, h}, PCL | ((i == 0) ? 27'h0 : CALL) | ((i == 2) ? FAST : 27'h0), 27'h0, 3'h7, {h, k});
			dc();
		end
		{b, h} = 15'($random(seed));
		add({8'hee, 2'h0, b[1:0], h[11:8]}, 27'h0, 27'h0, 3'h0, 20'h0);
		add({8'hf0, h[7:0]}, PTR, 27'h0, 3'h4, {6'h0, b[1:0], h});
		follow(1'b0);
		add({4'hf, h}, 27'h0, 27'h0, 3'h0, 20'h0);
		follow(1'b0);
		add(16'h0000, 27'h0, 27'h0, 3'h0, 20'h0);
		go();
		add(16'h0003, STBY, 27'h0, 3'h0, 20'h0);
		add(16'h0004, WDT, 27'h0, 3'h0, 20'h0);
		add(16'h0005, PUSH, 27'h0, 3'h0, 20'h0);
		add(16'h0006, POP, 27'h0, 3'h0, 20'h0);
		add(16'h00ff, SWR, 27'h0, 3'h0, 20'h0);
		follow(1'b0);
		for (int i = 0; i < 4; i++)
		begin
			add(16'h0010 | 16'(i), (i[1] ? RET : IRQ) | (i[0] ? FAST : 27'h0), PCL | (i[1] ? 27'h0 : RET),
				3'h0, 20'h0);
			follow(1'b1);
		end
		k = 8'($random(seed));
		add({8'h0c, k}, RET | WRL, PCL | ALUM, 3'h2, {12'h0, k});
		follow(1'b1);
		add({12'h010, k[3:0]}, BSL, 27'h0, 3'h6, {16'h0, k[3:0]});
		follow(1'b0);
		go();
		for (int i = 0; i < 7; i++)
		begin
			k = 8'($random(seed));
			add({(i == 0) ? 8'h0f : (i == 1) ? 8'h08 : (i == 2) ? 8'h0b : (i == 3) ? 8'h09 : (i == 4) ? 8'h0a :
				(i == 5) ? 8'h0e : 8'h0d, k}, (27'(i + 1) << 5) | ((i < 2) ? 27'h1f : (i < 5) ? 27'h05 : 27'h0),
				WRL, 3'h2, {12'h0, k});
		end
		go();
		for (int i = 0; i < 8; i++)
		begin
			add(16'h0008 | 16'(i), i[2] ? TWR : TRD, 27'h0, 3'h5, {17'h0, 1'b0, i[1:0]});
			dc();
		end
		go();
		// Earlier table writes stay busy until the memory side ends them
		chk({46'h0, busy}, 47'h1);
		done_in = 1'b1;
		@(negedge clk_in);
		done_in = 1'b0;
		chk({46'h0, busy}, 47'h0);
		for (int i = 0; i < 2; i++)
		begin
			add(16'h000c, TWR, 27'h0, 3'h5, 20'h0);
			dc();
			go();
			repeat (i[0] ? 2 : 20) @(negedge clk_in);
			chk({46'h0, busy}, 47'h1);
			done_in = 1'b1;
			@(negedge clk_in);
			done_in = 1'b0;
			chk({46'h0, busy}, 47'h0);
		end
		results();
	end
endmodule
`default_nettype wire
